/* verilog/iosam_map.svh */
`ifndef IOSAM_MAP_SVH
`define IOSAM_MAP_SVH
// Widths and slot counts.
`define IOSAM_CODE_W 8
`define IOSAM_N_DIN 6
`define IOSAM_N_DOUT 6
`define IOSAM_N_RIN 16
`define IOSAM_N_FUNC 256
`define IOSAM_ADDR_W 6
// Register addresses.
`define IOSAM_ADDR_DIN_SEL 6'h00
`define IOSAM_ADDR_DOUT_SEL 6'h08
`define IOSAM_ADDR_RIN_SEL 6'h10
`define IOSAM_ADDR_DIN_INV 6'h20
`define IOSAM_ADDR_DOUT_INV 6'h21
`define IOSAM_ADDR_DIN_STAT 6'h22
`define IOSAM_ADDR_DOUT_STAT 6'h23
// Selection codes with a special meaning.
`define IOSAM_CODE_NONE 8'h00
`define IOSAM_CODE_ALARM_CLEAR 8'h08
`define IOSAM_CODE_PANEL_LOCK 8'h0B
// Reset values, slot 0 in the low byte.
`define IOSAM_DIN_SEL_DEF {8'h31, 8'h30, 8'h08, 8'h05, 8'h01, 8'h25}
`define IOSAM_DOUT_SEL_DEF {8'h82, 8'h86, 8'h84, 8'h00, 8'h8A, 8'h90}
`define IOSAM_RIN_SEL_DEF 128'h0
`define IOSAM_DIN_INV_DEF 6'h00
`define IOSAM_DOUT_INV_DEF 6'h00
`define IOSAM_DIN_ALL 6'h3F
`define IOSAM_RIN_ALL 16'hFFFF
`define IOSAM_BYTE_ZERO 8'h00
`endif

/* verilog/iosam_pkg.sv */
`default_nettype none
`include "iosam_map.svh"
package iosam_pkg;
  typedef logic [`IOSAM_CODE_W-1:0] iosam_code_type;
  typedef logic [`IOSAM_ADDR_W-1:0] iosam_addr_type;
  typedef logic [`IOSAM_N_DIN-1:0][`IOSAM_CODE_W-1:0] iosam_dsel_type;
  typedef logic [`IOSAM_N_RIN-1:0][`IOSAM_CODE_W-1:0] iosam_rsel_type;
  typedef logic [`IOSAM_N_FUNC-1:0] iosam_func_type;

  // True when any active direct slot selects the given code.
  function automatic logic iosam_din_hit(iosam_dsel_type sel,
      logic [`IOSAM_N_DIN-1:0] lvl, iosam_code_type code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `IOSAM_N_DIN; i++) begin
      hit = hit | (lvl[i] & (sel[i] == code));
    end
    return hit;
  endfunction

  // True when any active fieldbus bit selects the given code.
  function automatic logic iosam_rin_hit(iosam_rsel_type sel,
      logic [`IOSAM_N_RIN-1:0] lvl, iosam_code_type code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `IOSAM_N_RIN; i++) begin
      hit = hit | (lvl[i] & (sel[i] == code));
    end
    return hit;
  endfunction

  // True when the address falls in the block of n registers at base.
  function automatic logic iosam_in_block(iosam_addr_type a, iosam_addr_type base,
      iosam_addr_type n);
    return (a >= base) && (a < iosam_addr_type'(base + n));
  endfunction
endpackage
`default_nettype wire

/* verilog/iosam_out_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iosam_map.svh"
module iosam_out_select (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire iosam_pkg::iosam_code_type sel,
  input wire iosam_pkg::iosam_func_type status_in,
  input wire logic invert,
  output logic pin
);
  import iosam_pkg::*;

  logic pin_d;
  logic pin_q;

  // Code zero forces logical OFF; the polarity bit then sets the current state.
  always_comb begin
    pin_d = ((sel == `IOSAM_CODE_NONE) ? 1'b0 : status_in[sel]) ^ invert;
  end

  // The terminal level is held in a flip-flop.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin = pin_q;
endmodule
`default_nettype wire

/* verilog/iosam_top.sv */
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "iosam_map.svh"
module iosam_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`IOSAM_N_DIN-1:0] din_pins,
  input wire logic [`IOSAM_N_RIN-1:0] fieldbus_bits,
  input wire iosam_pkg::iosam_func_type status_in,
  input wire iosam_pkg::iosam_addr_type reg_addr,
  input wire logic [`IOSAM_CODE_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`IOSAM_CODE_W-1:0] reg_rdata,
  output logic [`IOSAM_N_DOUT-1:0] dout_pins,
  output iosam_pkg::iosam_func_type func_active
);
  import iosam_pkg::*;

  iosam_dsel_type din_sel_d;
  iosam_dsel_type din_sel_q;
  iosam_dsel_type dout_sel_d;
  iosam_dsel_type dout_sel_q;
  iosam_rsel_type rin_sel_d;
  iosam_rsel_type rin_sel_q;
  logic [`IOSAM_N_DIN-1:0] din_inv_d;
  logic [`IOSAM_N_DIN-1:0] din_inv_q;
  logic [`IOSAM_N_DOUT-1:0] dout_inv_d;
  logic [`IOSAM_N_DOUT-1:0] dout_inv_q;
  logic [`IOSAM_CODE_W-1:0] rdata_d;
  logic [`IOSAM_CODE_W-1:0] rdata_q;
  iosam_func_type func_d;
  iosam_func_type func_q;
  logic [`IOSAM_N_DIN-1:0] din_level;
  logic lock_asg_dir;
  logic lock_asg_rem;
  logic lock_on_dir;
  logic lock_on_rem;
  logic alarm_hit_dir;
  logic alarm_hit_rem;
  logic alarm_other_sel;

  // Register writes update the selection and polarity tables.
  always_comb begin
    din_sel_d = din_sel_q;
    dout_sel_d = dout_sel_q;
    rin_sel_d = rin_sel_q;
    din_inv_d = din_inv_q;
    dout_inv_d = dout_inv_q;
    if (reg_wr) begin
      if (iosam_in_block(reg_addr, `IOSAM_ADDR_DIN_SEL, `IOSAM_ADDR_W'(`IOSAM_N_DIN))) begin
        din_sel_d[reg_addr[2:0]] = reg_wdata;
      end else if (iosam_in_block(reg_addr, `IOSAM_ADDR_DOUT_SEL,
          `IOSAM_ADDR_W'(`IOSAM_N_DOUT))) begin
        dout_sel_d[reg_addr[2:0]] = reg_wdata;
      end else if (iosam_in_block(reg_addr, `IOSAM_ADDR_RIN_SEL,
          `IOSAM_ADDR_W'(`IOSAM_N_RIN))) begin
        rin_sel_d[reg_addr[3:0]] = reg_wdata;
      end else if (reg_addr == `IOSAM_ADDR_DIN_INV) begin
        din_inv_d = reg_wdata[`IOSAM_N_DIN-1:0];
      end else if (reg_addr == `IOSAM_ADDR_DOUT_INV) begin
        dout_inv_d = reg_wdata[`IOSAM_N_DOUT-1:0];
      end
    end
  end

  // Tables load their defaults at reset.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      din_sel_q <= `IOSAM_DIN_SEL_DEF;
      dout_sel_q <= `IOSAM_DOUT_SEL_DEF;
      rin_sel_q <= `IOSAM_RIN_SEL_DEF;
      din_inv_q <= `IOSAM_DIN_INV_DEF;
      dout_inv_q <= `IOSAM_DOUT_INV_DEF;
    end else begin
      din_sel_q <= din_sel_d;
      dout_sel_q <= dout_sel_d;
      rin_sel_q <= rin_sel_d;
      din_inv_q <= din_inv_d;
      dout_inv_q <= dout_inv_d;
    end
  end

  // Reads answer in the next cycle only; unmapped addresses read zero.
  always_comb begin
    rdata_d = `IOSAM_BYTE_ZERO;
    if (reg_rd) begin
      if (iosam_in_block(reg_addr, `IOSAM_ADDR_DIN_SEL, `IOSAM_ADDR_W'(`IOSAM_N_DIN))) begin
        rdata_d = din_sel_q[reg_addr[2:0]];
      end else if (iosam_in_block(reg_addr, `IOSAM_ADDR_DOUT_SEL,
          `IOSAM_ADDR_W'(`IOSAM_N_DOUT))) begin
        rdata_d = dout_sel_q[reg_addr[2:0]];
      end else if (iosam_in_block(reg_addr, `IOSAM_ADDR_RIN_SEL,
          `IOSAM_ADDR_W'(`IOSAM_N_RIN))) begin
        rdata_d = rin_sel_q[reg_addr[3:0]];
      end else if (reg_addr == `IOSAM_ADDR_DIN_INV) begin
        rdata_d = {2'b00, din_inv_q};
      end else if (reg_addr == `IOSAM_ADDR_DOUT_INV) begin
        rdata_d = {2'b00, dout_inv_q};
      end else if (reg_addr == `IOSAM_ADDR_DIN_STAT) begin
        rdata_d = {2'b00, din_level};
      end else if (reg_addr == `IOSAM_ADDR_DOUT_STAT) begin
        rdata_d = {2'b00, dout_pins};
      end
    end
  end

  // Read data register.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_q <= `IOSAM_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Connector pins read high while current flows; NC slots invert to logical ON.
  assign din_level = din_pins ^ din_inv_q;

  // Panel interlock sources, seen as assigned and as active per side.
  assign lock_asg_dir = iosam_din_hit(din_sel_q, `IOSAM_DIN_ALL, `IOSAM_CODE_PANEL_LOCK);
  assign lock_asg_rem = iosam_rin_hit(rin_sel_q, `IOSAM_RIN_ALL, `IOSAM_CODE_PANEL_LOCK);
  assign lock_on_dir = iosam_din_hit(din_sel_q, din_level, `IOSAM_CODE_PANEL_LOCK);
  assign lock_on_rem = iosam_rin_hit(rin_sel_q, fieldbus_bits, `IOSAM_CODE_PANEL_LOCK);

  // Every function code other than the panel lock collects its slots; code zero never drives a function.
  always_comb begin
    func_d = '0;
    for (int c = 1; c < `IOSAM_N_FUNC; c++) begin
      func_d[c] = iosam_din_hit(din_sel_q, din_level, `IOSAM_CODE_W'(c))
        | iosam_rin_hit(rin_sel_q, fieldbus_bits, `IOSAM_CODE_W'(c));
    end
    if (!lock_asg_dir && !lock_asg_rem) begin
      func_d[`IOSAM_CODE_PANEL_LOCK] = 1'b1;
    end else if (lock_asg_dir && lock_asg_rem) begin
      func_d[`IOSAM_CODE_PANEL_LOCK] = lock_on_dir & lock_on_rem;
    end else begin
      func_d[`IOSAM_CODE_PANEL_LOCK] = lock_on_dir | lock_on_rem;
    end
  end

  // Function state register.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      func_q <= '0;
    end else begin
      func_q <= func_d;
    end
  end

  // One output selector per direct output terminal.
  genvar g;
  generate
    for (g = 0; g < `IOSAM_N_DOUT; g++) begin : g_dout
      iosam_out_select u_sel (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sel(dout_sel_q[g]),
        .status_in(status_in),
        .invert(dout_inv_q[g]),
        .pin(dout_pins[g])
      );
    end
  endgenerate

  assign reg_rdata = rdata_q;
  assign func_active = func_q;

  // Helper terms that only the checks below read.
  assign alarm_hit_dir = iosam_din_hit(din_sel_q, din_level, `IOSAM_CODE_ALARM_CLEAR);
  assign alarm_hit_rem = iosam_rin_hit(rin_sel_q, fieldbus_bits, `IOSAM_CODE_ALARM_CLEAR);
  assign alarm_other_sel = (din_sel_q[1] == `IOSAM_CODE_ALARM_CLEAR)
    | (din_sel_q[2] == `IOSAM_CODE_ALARM_CLEAR) | (din_sel_q[3] == `IOSAM_CODE_ALARM_CLEAR)
    | (din_sel_q[4] == `IOSAM_CODE_ALARM_CLEAR) | (din_sel_q[5] == `IOSAM_CODE_ALARM_CLEAR)
    | iosam_rin_hit(rin_sel_q, `IOSAM_RIN_ALL, `IOSAM_CODE_ALARM_CLEAR);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence lock_unassigned;
    !lock_asg_dir && !lock_asg_rem;
  endsequence

  sequence lock_both_dir_off;
    lock_asg_dir && lock_asg_rem && !lock_on_dir;
  endsequence

  sequence alarm_src_idle;
    !alarm_hit_dir && !alarm_hit_rem;
  endsequence

  // Direct input slot 0 drives its function one cycle later.
  AST_DIN_ROUTE: assert property (
    (din_sel_q[0] != `IOSAM_CODE_NONE) && (din_sel_q[0] != `IOSAM_CODE_PANEL_LOCK)
      && din_level[0] |=> func_q[$past(din_sel_q[0])])
    else $error("Direct input did not reach its function.");

  // Selection tables hold their defaults right after reset.
  AST_DIN_DEF: assert property (
    !$past(reset_n) |-> din_sel_q == `IOSAM_DIN_SEL_DEF)
    else $error("Direct input defaults wrong after reset.");

  AST_DOUT_ROUTE: assert property (
    dout_sel_q[1] != `IOSAM_CODE_NONE
      |=> dout_pins[1] == ($past(status_in[dout_sel_q[1]]) ^ $past(dout_inv_q[1])))
    else $error("Direct output does not follow its status signal.");

  AST_DOUT_DEF: assert property (
    !$past(reset_n) |-> dout_sel_q == `IOSAM_DOUT_SEL_DEF)
    else $error("Direct output defaults wrong after reset.");

  AST_RIN_DEF: assert property (
    !$past(reset_n) |-> rin_sel_q == `IOSAM_RIN_SEL_DEF)
    else $error("Fieldbus input defaults not all none.");

  AST_RIN_ROUTE: assert property (
    (rin_sel_q[0] != `IOSAM_CODE_NONE) && (rin_sel_q[0] != `IOSAM_CODE_PANEL_LOCK)
      && fieldbus_bits[0] |=> func_q[$past(rin_sel_q[0])])
    else $error("Fieldbus bit did not reach its function.");

  AST_OR_IDLE: assert property (
    alarm_src_idle |=> !func_q[`IOSAM_CODE_ALARM_CLEAR])
    else $error("Function active with no active source.");

  AST_OR_ANY: assert property (
    (alarm_hit_dir || alarm_hit_rem) ##1 1'b1 |-> func_q[`IOSAM_CODE_ALARM_CLEAR])
    else $error("Function inactive although a source is active.");

  AST_LOCK_FREE: assert property (
    lock_unassigned |=> func_q[`IOSAM_CODE_PANEL_LOCK])
    else $error("Unassigned interlock not held ON.");

  AST_LOCK_AND: assert property (
    lock_both_dir_off |=> !func_q[`IOSAM_CODE_PANEL_LOCK])
    else $error("Interlock ON while direct side is OFF.");

  AST_NC_INPUT: assert property (
    (din_sel_q[0] == `IOSAM_CODE_ALARM_CLEAR) && !alarm_other_sel && din_inv_q[0]
      && din_pins[0] |=> !func_q[`IOSAM_CODE_ALARM_CLEAR])
    else $error("Normally-closed input not inverted.");

  AST_NO_FUNC_OFF: assert property (
    dout_sel_q[2] == `IOSAM_CODE_NONE |=> dout_pins[2] == $past(dout_inv_q[2]))
    else $error("Output with code zero not held OFF.");

  // A normally-closed slot 0 without current reaches its function one cycle later.
  AST_NC_ROUTE: assert property (
    (din_sel_q[0] != `IOSAM_CODE_NONE) && (din_sel_q[0] != `IOSAM_CODE_PANEL_LOCK)
      && din_inv_q[0] && !din_pins[0] |=> func_q[$past(din_sel_q[0])])
    else $error("Normally-closed input without current not ON.");

  // Direct output slot 5 follows its status signal and its polarity.
  AST_DOUT_ROUTE_LAST: assert property (
    dout_sel_q[5] != `IOSAM_CODE_NONE
      |=> dout_pins[5] == ($past(status_in[dout_sel_q[5]]) ^ $past(dout_inv_q[5])))
    else $error("Last direct output does not follow its status signal.");

  // An interlock assigned on the direct side only follows that side.
  AST_LOCK_DIR_ONLY: assert property (
    lock_asg_dir && !lock_asg_rem |=> func_q[`IOSAM_CODE_PANEL_LOCK] == $past(lock_on_dir))
    else $error("Interlock on the direct side only does not follow it.");

  // With the interlock on both sides, both sources ON give ON.
  AST_LOCK_BOTH_ON: assert property (
    lock_asg_dir && lock_asg_rem && lock_on_dir && lock_on_rem
      |=> func_q[`IOSAM_CODE_PANEL_LOCK])
    else $error("Interlock OFF although both sides are ON.");

  // With the interlock on both sides, a fieldbus source OFF gives OFF.
  AST_LOCK_REM_OFF: assert property (
    lock_asg_dir && lock_asg_rem && !lock_on_rem |=> !func_q[`IOSAM_CODE_PANEL_LOCK])
    else $error("Interlock ON while fieldbus side is OFF.");

  // A read of a direct input slot returns its selection code in the next cycle.
  AST_DIN_SEL_READ: assert property (
    reg_rd && iosam_in_block(reg_addr, `IOSAM_ADDR_DIN_SEL, `IOSAM_ADDR_W'(`IOSAM_N_DIN))
      |=> reg_rdata == $past(din_sel_q[reg_addr[2:0]]))
    else $error("Direct input selection code read back wrong.");

  // Without a read strobe the read data return to zero.
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == `IOSAM_BYTE_ZERO)
    else $error("Read data stand longer than one cycle.");

  // Fieldbus bits at code zero with idle terminals raise only the free interlock.
  AST_RIN_NONE: assert property (
    (rin_sel_q == `IOSAM_RIN_SEL_DEF) && !lock_asg_dir && !(|din_level)
      |=> $onehot(func_q) && func_q[`IOSAM_CODE_PANEL_LOCK])
    else $error("Fieldbus bit without a code raised a function.");
endmodule
`default_nettype wire

/* verification/iosam_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iosam_map.svh"
// Outside controller: it presents the requested terminal and fieldbus levels a clock later.
module iosam_ctrl_model (
  input wire logic core_clk,
  input wire logic [`IOSAM_N_DIN-1:0] din_req,
  input wire logic [`IOSAM_N_RIN-1:0] rin_req,
  output logic [`IOSAM_N_DIN-1:0] din_pins,
  output logic [`IOSAM_N_RIN-1:0] fieldbus_bits
);
  // Wiring and cyclic data both lag the request by one clock.
  initial begin
    din_pins = 6'h00;
    fieldbus_bits = 16'h0000;
  end
  always @(posedge core_clk) begin
    din_pins <= din_req;
    fieldbus_bits <= rin_req;
  end
endmodule
`default_nettype wire

/* verification/tb_io_signal_assignment_matrix.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iosam_map.svh"
module tb_io_signal_assignment_matrix;
  import iosam_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] idx;
    logic [7:0] exp;
  } iosam_note_type;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] din_req = 6'h00;
  logic [15:0] rin_req = 16'h0000;
  logic [5:0] din_pins;
  logic [15:0] fieldbus_bits;
  iosam_func_type status_in = 256'h0;
  iosam_addr_type reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic probe = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] dout_pins;
  iosam_func_type func_active;
  iosam_note_type notes[$];
  iosam_note_type cur;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 32'hA817;
  logic [7:0] din_def [6] = '{8'h25, 8'h01, 8'h05, 8'h08, 8'h30, 8'h31};
  logic [7:0] dout_code [6] = '{8'h90, 8'h8A, 8'h00, 8'h84, 8'h86, 8'h82};
  logic [5:0] dout_inv;
  logic [5:0] exp_dout;

  iosam_ctrl_model ctrl (.core_clk(core_clk), .din_req(din_req), .rin_req(rin_req),
    .din_pins(din_pins), .fieldbus_bits(fieldbus_bits));
  iosam_top dut (.core_clk(core_clk), .reset_n(reset_n), .din_pins(din_pins),
    .fieldbus_bits(fieldbus_bits), .status_in(status_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dout_pins(dout_pins), .func_active(func_active));

  // Clock source at 25 MHz.
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic report(string what, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (e !== s) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cmp_rd(iosam_note_type n);
    report("reg_rdata", n.exp, reg_rdata);
  endtask
  task automatic cmp_func(iosam_note_type n);
    report("func_active", n.exp, {7'h00, func_active[n.idx]});
  endtask
  task automatic cmp_dout(iosam_note_type n);
    report("dout_pins", n.exp, {2'h0, dout_pins});
  endtask

  // Single-cycle register write.
  task automatic reg_write(int a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= iosam_addr_type'(a);
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Single-cycle register read; the answer is noted for the monitor.
  task automatic reg_read(int a, logic [7:0] e);
    notes.push_back({2'h0, 8'(a), e});
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= iosam_addr_type'(a);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // Lets new levels pass model and design, then asks for one look at an output.
  task automatic expect_lvl(logic [1:0] k, logic [7:0] idx, logic [7:0] e);
    repeat (3) @(posedge core_clk);
    notes.push_back({k, idx, e});
    probe <= 1'b1;
    @(posedge core_clk);
    probe <= 1'b0;
  endtask

  // Monitor: read data stand only in the cycle after the strobe.
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
  end
  always @(negedge core_clk) begin
    if ((rd_d || probe) && notes.size() > 0) begin
      cur = notes.pop_front();
      case (cur.kind)
        2'h0: cmp_rd(cur);
        2'h1: cmp_func(cur);
        default: cmp_dout(cur);
      endcase
    end
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      reg_read(`IOSAM_ADDR_DIN_SEL + i, din_def[i]);
      reg_read(`IOSAM_ADDR_DOUT_SEL + i, dout_code[i]);
    end
    for (int i = 0; i < 16; i++) begin
      reg_read(`IOSAM_ADDR_RIN_SEL + i, 8'h00);
    end
    reg_read(6'h30, 8'h00);
    expect_lvl(2'h1, 8'h0B, 8'h01);
    expect_lvl(2'h1, 8'h00, 8'h00);
    // Each terminal alone raises its own default function, not that of the next slot.
    for (int i = 0; i < 6; i++) begin
      din_req <= 6'h01 << i;
      expect_lvl(2'h1, din_def[i], 8'h01);
      expect_lvl(2'h1, din_def[(i + 1) % 6], 8'h00);
    end
    din_req <= 6'h00;
    reg_write(`IOSAM_ADDR_DIN_INV, 8'h01);
    expect_lvl(2'h1, 8'h25, 8'h01);
    reg_write(`IOSAM_ADDR_DIN_INV, 8'h00);
    // Alarm clear shared by a terminal and a fieldbus bit.
    reg_write(`IOSAM_ADDR_DIN_SEL + 1, 8'h08);
    reg_write(`IOSAM_ADDR_RIN_SEL + 4, 8'h08);
    din_req <= 6'h02;
    expect_lvl(2'h1, 8'h08, 8'h01);
    din_req <= 6'h00;
    rin_req <= 16'h0010;
    expect_lvl(2'h1, 8'h08, 8'h01);
    rin_req <= 16'h0000;
    expect_lvl(2'h1, 8'h08, 8'h00);
    // Interlock on both sides needs both sources on.
    reg_write(`IOSAM_ADDR_DIN_SEL, 8'h0B);
    reg_write(`IOSAM_ADDR_RIN_SEL + 2, 8'h0B);
    for (int c = 0; c < 4; c++) begin
      din_req <= {5'h00, c[0]};
      rin_req <= {13'h0000, c[1], 2'h0};
      expect_lvl(2'h1, 8'h0B, {7'h00, c == 3});
    end
    // Outputs follow random status words, slot 2 stays at code zero.
    reg_write(`IOSAM_ADDR_DOUT_SEL + 5, 8'h0B);
    dout_code[5] = 8'h0B;
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 8; j++) begin
        status_in[j * 32 +: 32] <= $random(seed);
      end
      dout_inv = (k < 2) ? 6'h00 : 6'($random(seed));
      reg_write(`IOSAM_ADDR_DOUT_INV, {2'h0, dout_inv});
      for (int i = 0; i < 6; i++) begin
        exp_dout[i] = (dout_code[i] == 8'h00 ? 1'b0 : status_in[dout_code[i]]) ^ dout_inv[i];
      end
      expect_lvl(2'h2, 8'h00, {2'h0, exp_dout});
      reg_read(`IOSAM_ADDR_DOUT_STAT, {2'h0, exp_dout});
    end
    // A second reset brings the rewritten slots back to their defaults.
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    reg_read(`IOSAM_ADDR_DIN_SEL, 8'h25);
    reg_read(`IOSAM_ADDR_DOUT_SEL + 5, 8'h82);
    reg_read(`IOSAM_ADDR_RIN_SEL + 4, 8'h00);
    // Let the last answer reach the monitor; a note left unanswered is a mismatch.
    repeat (2) @(posedge core_clk);
    if (notes.size() != 0) begin
      fail_count++;
    end
    stop_test();
  end
endmodule
`default_nettype wire
